// File: rtl/eeprom_access_map.vh
// register map, field positions, reset values and timing for the bit-serial store
`ifndef EEPROM_ACCESS_MAP_VH
`define EEPROM_ACCESS_MAP_VH

// register addresses on the plain register port
`define ADDR_BIT_SELECT 8'h0e
`define ADDR_STATUS_CONTROL 8'h0f
`define ADDR_WIDTH 8
`define DATA_WIDTH 8

// bit-select register fields
`define SEL_SPARE 7
`define SEL_ROW_HI 6
`define SEL_ROW_LO 3
`define SEL_COL_HI 2
`define SEL_COL_LO 0
`define SEL_ADDR_HI 6
`define BIT_SELECT_RESET 8'h00

// status/control register fields
`define SC_SENSE_DATA 7
`define SC_PUMP_CLOCK 6
`define SC_PUMP_ENABLE 5
`define SC_PROGRAM 4
`define SC_ROW_ERASE 3
`define SC_ARRAY_ERASE 2
`define SC_UNUSED 1
`define SC_COL_ZERO 0
`define CONTROL_RESET 1'b0
`define COL_ZERO_RESET 1'b1
`define READ_IDLE 8'h00

// array geometry
`define ARRAY_BITS 128
`define ROW_COUNT 16
`define COL_COUNT 8
`define ROW_WIDTH 4
`define COL_WIDTH 3
`define INDEX_WIDTH 7
`define CELLS_CLEAR 128'h0000_0000_0000_0000_0000_0000_0000_0000

// pump startup time and its cycle count at the system clock rate
`define SYS_CLK_MHZ 25
`define PUMP_STARTUP_NS 2000
`define PUMP_STARTUP_CYCLES ((`PUMP_STARTUP_NS * `SYS_CLK_MHZ + 999) / 1000)
`define PUMP_COUNT_WIDTH 8

`endif

// File: rtl/nvm_bit_array.v
// 128-cell nonvolatile bit array with one shared sense output
`timescale 1ns/1ps
`include "eeprom_access_map.vh"

module nvm_bit_array (
  input wire sys_clk,
  input wire [`ROW_WIDTH-1:0] row,
  input wire [`COL_WIDTH-1:0] column,
  input wire program_strobe,
  input wire row_erase_strobe,
  input wire array_erase_strobe,
  output wire sense_bit
);

  // cells are never reset: they model nonvolatile contents
  reg [`ARRAY_BITS-1:0] cells;
  integer i;

  // single sense amplifier looks at the one selected cell
  assign sense_bit = cells[{row, column}];

  // array erase beats row erase, which beats program
  always @(posedge sys_clk) begin
    if (array_erase_strobe) begin
      cells <= `CELLS_CLEAR;
    end else if (row_erase_strobe) begin
      // walk the columns of the addressed row only
      for (i = 0; i < `COL_COUNT; i = i + 1) begin
        cells[{row, i[`COL_WIDTH-1:0]}] <= 1'b0;
      end
    end else if (program_strobe) begin
      cells[{row, column}] <= 1'b1;
    end
  end

endmodule // nvm_bit_array

// File: rtl/charge_pump_control.v
// charge pump on/off control with startup timing
`timescale 1ns/1ps
`include "eeprom_access_map.vh"

module charge_pump_control (
  input wire sys_clk,
  input wire reset_n,
  input wire pump_enable_bit,
  input wire op_request,
  output reg pump_running,
  output reg pump_ready
);

  // last startup cycle; the full value is cut on purpose to the counter's width
  localparam integer STARTUP_LAST_FULL = `PUMP_STARTUP_CYCLES - 1;
  localparam [`PUMP_COUNT_WIDTH-1:0] STARTUP_LAST = STARTUP_LAST_FULL[`PUMP_COUNT_WIDTH-1:0];

  reg [`PUMP_COUNT_WIDTH-1:0] startup_count;

  // the pump starts only with its enable; once ready it holds until no op remains
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      pump_running <= 1'b0;
      pump_ready <= 1'b0;
      startup_count <= {`PUMP_COUNT_WIDTH{1'b0}};
    end else if (op_request && (pump_enable_bit || pump_ready)) begin
      pump_running <= 1'b1;
      if (!pump_ready) begin
        if (startup_count == STARTUP_LAST)
          pump_ready <= 1'b1;
        startup_count <= startup_count + 1'b1;
      end
    end else begin
      // dropping out before startup ends restarts the wait next time
      pump_running <= 1'b0;
      pump_ready <= 1'b0;
      startup_count <= {`PUMP_COUNT_WIDTH{1'b0}};
    end
  end

endmodule // charge_pump_control

// File: rtl/bit_serial_eeprom_access.v
// register interface and control for the bit-serial nonvolatile array
//
// Contract
// - hold 128 nonvolatile single bits
// - sixteen rows of eight, one sense amp
// - bit-select at lower address, feeds decoders
// - bits 6..3 row, bits 2..0 column
// - top select bit is plain storage
// - reset clears the whole bit-select register
// - status/control at next address, five bits
// - bit one reads zero always
// - reset clears control, sets column-zero flag
// - column-zero flag follows selected column
// - pump clock select, one is bus clock
// - pump on needs enable plus an operation
// - ready pump runs until operations cleared
// - sense data undefined while pump enabled
// - program writes one into selected cell
// - row erase zeroes the addressed row
// - array erase zeroes everything, overrides row
// - read-only sense data of selected cell
`timescale 1ns/1ps
`include "eeprom_access_map.vh"

module bit_serial_eeprom_access (
  input wire sys_clk,
  input wire reset_n,
  input wire [`ADDR_WIDTH-1:0] reg_addr,
  input wire [`DATA_WIDTH-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [`DATA_WIDTH-1:0] reg_rdata,
  output reg [`ROW_COUNT-1:0] row_decode,
  output reg [`COL_COUNT-1:0] column_decode,
  output wire pump_on,
  output wire pump_ready,
  output reg pump_clock_select
);

  // decode of a row number into one row line
  function [`ROW_COUNT-1:0] row_lines;
    input [`DATA_WIDTH-1:0] select;
    begin
      row_lines = {`ROW_COUNT{1'b0}};
      row_lines[select[`SEL_ROW_HI:`SEL_ROW_LO]] = 1'b1;
    end
  endfunction

  // decode of a column number into one column line
  function [`COL_COUNT-1:0] column_lines;
    input [`DATA_WIDTH-1:0] select;
    begin
      column_lines = {`COL_COUNT{1'b0}};
      column_lines[select[`SEL_COL_HI:`SEL_COL_LO]] = 1'b1;
    end
  endfunction

  // true when the select value points at the first column of a row
  function is_first_column;
    input [`DATA_WIDTH-1:0] select;
    begin
      is_first_column = (select[`SEL_COL_HI:`SEL_COL_LO] == {`COL_WIDTH{1'b0}});
    end
  endfunction

  // software-visible state
  reg [`DATA_WIDTH-1:0] bit_select;
  reg pump_enable_bit;
  reg program_bit;
  reg row_erase_bit;
  reg array_erase_bit;
  reg column_zero_flag;

  // next values for the select path
  reg [`DATA_WIDTH-1:0] next_bit_select;
  reg next_column_zero_flag;

  // next values for the control bits
  reg next_pump_clock_select;
  reg next_pump_enable_bit;
  reg next_program_bit;
  reg next_row_erase_bit;
  reg next_array_erase_bit;

  // read path
  reg [`DATA_WIDTH-1:0] next_reg_rdata;
  reg [`DATA_WIDTH-1:0] status_view;

  // array and pump hookup
  wire sense_bit;
  wire op_request;
  wire program_strobe;
  wire row_erase_strobe;
  wire array_erase_strobe;

  // address hits
  wire hit_select;
  wire hit_status;

  assign hit_select = (reg_addr == `ADDR_BIT_SELECT);
  assign hit_status = (reg_addr == `ADDR_STATUS_CONTROL);

  // any program or erase bit asks for the pump
  assign op_request = program_bit | row_erase_bit | array_erase_bit;

  // the array only sees programming voltage once the pump is up
  assign program_strobe = program_bit & pump_ready;
  assign row_erase_strobe = row_erase_bit & pump_ready;
  assign array_erase_strobe = array_erase_bit & pump_ready;

  // next value of the bit-select register, all eight bits writable
  always @* begin
    next_bit_select = bit_select;
    if (reg_write && hit_select)
      next_bit_select = reg_wdata;
  end

  // flag tracks the column of the value about to be held
  always @* begin
    next_column_zero_flag = is_first_column(next_bit_select);
  end

  // next values of the writable status/control bits
  always @* begin
    next_pump_clock_select = pump_clock_select;
    next_pump_enable_bit = pump_enable_bit;
    next_program_bit = program_bit;
    next_row_erase_bit = row_erase_bit;
    next_array_erase_bit = array_erase_bit;
    if (reg_write && hit_status) begin
      // sense data, bit one and the column flag ignore writes
      next_pump_clock_select = reg_wdata[`SC_PUMP_CLOCK];
      next_pump_enable_bit = reg_wdata[`SC_PUMP_ENABLE];
      next_program_bit = reg_wdata[`SC_PROGRAM];
      next_row_erase_bit = reg_wdata[`SC_ROW_ERASE];
      next_array_erase_bit = reg_wdata[`SC_ARRAY_ERASE];
    end
  end

  // bit-select register and the decoders it drives
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      bit_select <= `BIT_SELECT_RESET;
      row_decode <= row_lines(`BIT_SELECT_RESET);
      column_decode <= column_lines(`BIT_SELECT_RESET);
      column_zero_flag <= `COL_ZERO_RESET;
    end else begin
      bit_select <= next_bit_select;
      // decoders load on the same edge as the register itself
      row_decode <= row_lines(next_bit_select);
      column_decode <= column_lines(next_bit_select);
      column_zero_flag <= next_column_zero_flag;
    end
  end

  // status/control bits
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      pump_clock_select <= `CONTROL_RESET;
      pump_enable_bit <= `CONTROL_RESET;
      program_bit <= `CONTROL_RESET;
      row_erase_bit <= `CONTROL_RESET;
      array_erase_bit <= `CONTROL_RESET;
    end else begin
      pump_clock_select <= next_pump_clock_select;
      pump_enable_bit <= next_pump_enable_bit;
      program_bit <= next_program_bit;
      row_erase_bit <= next_row_erase_bit;
      array_erase_bit <= next_array_erase_bit;
    end
  end

  // assembled view of the status/control register
  always @* begin
    status_view = `READ_IDLE;
    // sense is raw even with the pump enabled; software must not trust it then
    status_view[`SC_SENSE_DATA] = sense_bit;
    status_view[`SC_PUMP_CLOCK] = pump_clock_select;
    status_view[`SC_PUMP_ENABLE] = pump_enable_bit;
    status_view[`SC_PROGRAM] = program_bit;
    status_view[`SC_ROW_ERASE] = row_erase_bit;
    status_view[`SC_ARRAY_ERASE] = array_erase_bit;
    status_view[`SC_UNUSED] = 1'b0;
    status_view[`SC_COL_ZERO] = column_zero_flag;
  end

  // read mux; unmapped addresses and idle cycles return zero
  always @* begin
    next_reg_rdata = `READ_IDLE;
    if (reg_read) begin
      if (hit_select)
        next_reg_rdata = bit_select;
      else if (hit_status)
        next_reg_rdata = status_view;
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (!reset_n)
      reg_rdata <= `READ_IDLE;
    else
      reg_rdata <= next_reg_rdata;
  end

  // the nonvolatile cells, addressed by the held select value
  nvm_bit_array array_cells (
    .sys_clk(sys_clk),
    .row(bit_select[`SEL_ROW_HI:`SEL_ROW_LO]),
    .column(bit_select[`SEL_COL_HI:`SEL_COL_LO]),
    .program_strobe(program_strobe),
    .row_erase_strobe(row_erase_strobe),
    .array_erase_strobe(array_erase_strobe),
    .sense_bit(sense_bit)
  );

  // pump sequencing; a ready pump ignores a later clear of its enable
  charge_pump_control pump (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pump_enable_bit(pump_enable_bit),
    .op_request(op_request),
    .pump_running(pump_on),
    .pump_ready(pump_ready)
  );

endmodule // bit_serial_eeprom_access

// File: bench/eeprom_access_chk.sv
// assertion checker for the bit-serial store register block
`timescale 1ns/1ps
module eeprom_access_chk (
  input wire sys_clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire [15:0] row_decode,
  input wire [7:0] column_decode,
  input wire pump_on,
  input wire pump_ready,
  input wire pump_clock_select
);
  reg [7:0] wd;
  reg [5:2] ctl;
  reg [7:0] on_cnt;
  // shadow of the previous cycle's write data and of the written control bits; the run counter saturates
  always @(posedge sys_clk) begin
    wd <= reg_wdata;
    if (!reset_n || (reg_write && reg_addr == 8'h0f))
      ctl <= reset_n ? reg_wdata[5:2] : 4'h0;
    if (!reset_n || !pump_on)
      on_cnt <= 8'h00;
    else if (on_cnt != 8'hff)
      on_cnt <= on_cnt + 8'h01;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_sel_write;
    reg_write && reg_addr == 8'h0e;
  endsequence
  sequence s_sel_seen;
    row_decode == 16'h0001 << wd[6:3] && column_decode == 8'h01 << wd[2:0];
  endsequence
  property p_sel; s_sel_write |=> s_sel_seen; endproperty
  a_sel: assert property (p_sel) else $error("selection differs from written value");
  property p_flag; reg_read && reg_addr == 8'h0f |=> reg_rdata[0] == column_decode[0]; endproperty
  a_flag: assert property (p_flag) else $error("column zero flag wrong");
  property p_bit1; reg_read && reg_addr == 8'h0f |=> !reg_rdata[1]; endproperty
  a_bit1: assert property (p_bit1) else $error("unused bit reads one");
  property p_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_rst;
    $rose(reset_n) |-> row_decode == 16'h0001 && column_decode == 8'h01 && !pump_on
      && !pump_clock_select;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_clk; reg_write && reg_addr == 8'h0f |=> pump_clock_select == wd[6]; endproperty
  a_clk: assert property (p_clk) else $error("pump clock select not written");
  property p_off; ctl[4:2] == 3'b000 |=> !pump_on && !pump_ready; endproperty
  a_off: assert property (p_off) else $error("pump runs without operation");
  property p_cold; !pump_ready && !ctl[5] |=> !pump_on; endproperty
  a_cold: assert property (p_cold) else $error("pump starts without enable");
  property p_hold; pump_ready && ctl[4:2] != 3'b000 |=> pump_on && pump_ready; endproperty
  a_hold: assert property (p_hold) else $error("ready pump stopped early");
  property p_late; pump_ready |-> on_cnt >= 8'd48; endproperty
  a_late: assert property (p_late) else $error("pump ready too soon");
endmodule // eeprom_access_chk

bind bit_serial_eeprom_access eeprom_access_chk chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .row_decode(row_decode), .column_decode(column_decode),
  .pump_on(pump_on), .pump_ready(pump_ready), .pump_clock_select(pump_clock_select));

// File: bench/tb.sv
// self-checking bench for the bit-serial store register block
`timescale 1ns/1ps
module tb;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  wire [7:0] reg_rdata;
  wire [15:0] row_decode;
  wire [7:0] column_decode;
  wire pump_on;
  wire pump_ready;
  wire pump_clock_select;
  integer fail_count = 0;
  integer samples_checked = 0;
  integer seed = 91882;
  integer i;
  reg [127:0] cells;
  reg [7:0] d;
  reg [7:0] s;
  bit_serial_eeprom_access uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .row_decode(row_decode), .column_decode(column_decode), .pump_on(pump_on),
    .pump_ready(pump_ready), .pump_clock_select(pump_clock_select));
  // 40 ns clock
  always #20 sys_clk = ~sys_clk;
  task chk(input string name, input [15:0] e, input [15:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (e !== g) begin
        fail_count = fail_count + 1;
        $display("mismatch %s expected %h seen %h", name, e, g);
      end
    end
  endtask
  // one-cycle strobes, released on the edge that takes them
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1;
      v = reg_rdata;
    end
  endtask
  // expected array after one operation; array erase wins over row erase
  function [127:0] apply(input [127:0] c, input [6:0] x, input [7:0] code);
    begin
      if (code[2])
        apply = 128'h0;
      else if (code[3])
        apply = c & ~(128'hff << {x[6:3], 3'b000});
      else
        apply = c | (128'h1 << x);
    end
  endfunction
  // enable dropped once ready must not stop the pump
  task op(input [7:0] x, input [7:0] code);
    begin
      wr(8'h0e, x);
      wr(8'h0f, code);
      repeat (52) @(posedge sys_clk);
      #1;
      chk("pump_ready", 1, pump_ready);
      wr(8'h0f, code & 8'hdf);
      @(posedge sys_clk);
      #1;
      chk("pump_held", 1, pump_on);
      wr(8'h0f, 8'h00);
      @(posedge sys_clk);
      #1;
      chk("pump_stop", 0, pump_on);
      cells = apply(cells, x[6:0], code);
    end
  endtask
  // read every cell back through select and sense bit
  task scan;
    begin
      for (i = 0; i < 128; i = i + 1) begin
        wr(8'h0e, i[7:0]);
        chk("row", 16'h0001 << i[6:3], row_decode);
        rd(8'h0f, d);
        chk("cell", cells[i], d[7]);
        chk("flag", i[2:0] == 3'd0, d[0]);
      end
    end
  endtask
  task final_report;
    begin
      if (fail_count == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // hang guard, well beyond the expected run
  initial begin
    #2_000_000;
    fail_count = fail_count + 1;
    final_report;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h0e, d);
    chk("sel_reset", 8'h00, d);
    rd(8'h0f, d);
    chk("status_reset", 7'h01, d[6:0]);
    for (i = 0; i < 24; i = i + 1) begin
      s = $random(seed);
      if (i < 2)
        s = i ? 8'h80 : 8'hff;
      wr(8'h0e, s);
      chk("column", 8'h01 << s[2:0], column_decode);
      rd(8'h0e, d);
      chk("sel", s, d);
    end
    wr(8'h33, 8'h55);
    rd(8'h0e, d);
    chk("unmapped_wr", s, d);
    rd(8'h33, d);
    chk("unmapped_rd", 8'h00, d);
    wr(8'h0f, 8'hc3);
    chk("clock_sel", 1, pump_clock_select);
    rd(8'h0f, d);
    chk("status_rw", 6'h20, d[6:1]);
    wr(8'h0f, 8'h10);
    repeat (60) @(posedge sys_clk);
    #1;
    chk("no_enable", 0, pump_on);
    wr(8'h0f, 8'h00);
    op(8'h00, 8'h24);
    scan;
    for (i = 0; i < 6; i = i + 1) begin
      s = $random(seed);
      op(s & 8'h7f, 8'h30);
    end
    op(s & 8'h7f, 8'h28);
    scan;
    // mid-run reset: select and control clear, the cells keep their contents
    wr(8'h0e, 8'h7f);
    wr(8'h0f, 8'h40);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h0e, d);
    chk("sel_rerun", 8'h00, d);
    rd(8'h0f, d);
    chk("status_rerun", {cells[0], 7'h01}, d);
    op(8'h05, 8'h2c);
    scan;
    final_report;
  end
endmodule // tb
